/* File: logic/cpm_pkg.sv */
package cpm_pkg;
	// -------------------------------------------------------------
	// function codes for multifunction pins
	// -------------------------------------------------------------
	localparam int FUNC_W = 3;
	typedef enum logic [2:0] {
		CPM_FN_DEFAULT = 3'h0,
		CPM_FN_GPIN = 3'h1,
		CPM_FN_GPOUT = 3'h2,
		CPM_FN_IRQ1 = 3'h3,
		CPM_FN_IRQ2 = 3'h4,
		CPM_FN_CLKIN = 3'h5
	} cpm_func_type;
	// pll reference sources
	typedef enum logic [1:0] {
		CPM_PLL_MCLK = 2'h0,
		CPM_PLL_BCLK = 2'h1,
		CPM_PLL_DIN = 2'h2,
		CPM_PLL_GPIO = 2'h3
	} cpm_pll_src_type;
	// codec clock sources
	typedef enum logic [1:0] {
		CPM_CDC_MCLK = 2'h0,
		CPM_CDC_BCLK = 2'h1,
		CPM_CDC_GPIO = 2'h2,
		CPM_CDC_PLL = 2'h3
	} cpm_cdc_src_type;
	localparam int PWR_W = 4;
	localparam logic [PWR_W-1:0] PWR_RESET = 4'h0;
	// configuration carried as one struct
	typedef struct packed {
		cpm_func_type fn_din;
		cpm_func_type fn_dout;
		cpm_func_type fn_sclk;
		cpm_func_type fn_miso;
		cpm_func_type fn_gpio;
		cpm_pll_src_type pll_src;
		cpm_cdc_src_type cdc_src;
		logic [2:0] gpo_val;
		logic [PWR_W-1:0] pwr_en;
	} cpm_cfg_type;
	localparam cpm_cfg_type CFG_RESET = '{CPM_FN_DEFAULT, CPM_FN_DEFAULT, CPM_FN_DEFAULT,
		CPM_FN_DEFAULT, CPM_FN_DEFAULT, CPM_PLL_MCLK, CPM_CDC_MCLK, 3'h0, PWR_RESET};
	// raw pin inputs
	typedef struct packed {
		logic mclk;
		logic bclk;
		logic wclk;
		logic din;
		logic sclk;
		logic gpio;
		logic bus_sel;
		logic bus_a;
		logic bus_b;
	} cpm_pins_type;
endpackage : cpm_pkg

/* File: logic/cpm_sync.sv */
`timescale 1ns/1ns
module cpm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	if (WIDTH < 1) begin : g_width_check
		$error("cpm_sync width must be at least one");
	end
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s1_next;
	logic [WIDTH-1:0] q_next;
	always_comb begin
		s1_next = d;
		q_next = s1_reg;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s1_reg <= '0;
			q <= '0;
		end else begin
			s1_reg <= s1_next;
			q <= q_next;
		end
	end
endmodule : cpm_sync

/* File: logic/cpm_pin_mux.sv */
`timescale 1ns/1ns
//
// Contract
// - select pin level chooses i2c or spi
// - reset and select fixed; others register driven
// - pins reset to default role
// - analog blocks off until each enabled
// - pll reference from four pins
// - three gp outputs on own pins
// - three gp inputs on own pins
// - exclusive pin serves one function only
// - mclk or bclk feed several clocks
module cpm_pin_mux
	import cpm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// configuration from the register file
	input wire cpm_cfg_type cfg,
	input wire logic irq1_evt,
	input wire logic irq2_evt,
	input wire logic dout_data,
	// pins in
	input wire cpm_pins_type pins_in,
	// pin drivers
	output logic dout_o,
	output logic dout_oe,
	output logic miso_o,
	output logic miso_oe,
	output logic gpio_o,
	output logic gpio_oe,
	// decoded functions
	output logic use_spi,
	output logic i2c_scl,
	output logic i2c_sda,
	output logic spi_ss,
	output logic spi_mosi,
	output logic pll_ref,
	output logic codec_clk,
	output logic bclk_int,
	output logic [2:0] gpi_val,
	output logic [PWR_W-1:0] pwr_on
);
	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	// only sampled signal levels; real clocks would use dedicated muxes
	cpm_pins_type ps;
	cpm_sync #(.WIDTH($bits(cpm_pins_type))) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.d(pins_in),
		.q(ps)
	);
	// -------------------------------------------------------------
	// configuration hold
	// -------------------------------------------------------------
	cpm_cfg_type cfg_reg;
	cpm_cfg_type cfg_next;
	always_comb begin
		cfg_next = cfg;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg_reg <= CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end
	// -------------------------------------------------------------
	// output decode
	// -------------------------------------------------------------
	logic dout_o_next, dout_oe_next, miso_o_next, miso_oe_next, gpio_o_next, gpio_oe_next;
	logic use_spi_next, i2c_scl_next, i2c_sda_next, spi_ss_next, spi_mosi_next;
	logic pll_ref_next, codec_clk_next, bclk_int_next;
	logic [2:0] gpi_next;
	logic [PWR_W-1:0] pwr_next;
	always_comb begin
		// control bus pins follow the static select level
		use_spi_next = ps.bus_sel;
		i2c_scl_next = ps.bus_sel ? 1'h1 : ps.bus_a;
		i2c_sda_next = ps.bus_sel ? 1'h1 : ps.bus_b;
		spi_ss_next = ps.bus_sel ? ps.bus_a : 1'h1;
		spi_mosi_next = ps.bus_sel ? ps.bus_b : 1'h0;
		// dout pin: one function at a time by case
		dout_o_next = 1'h0;
		dout_oe_next = 1'h1;
		case (cfg_reg.fn_dout)
			CPM_FN_DEFAULT: dout_o_next = dout_data;
			CPM_FN_GPOUT: dout_o_next = cfg_reg.gpo_val[0];
			CPM_FN_IRQ1: dout_o_next = irq1_evt;
			CPM_FN_IRQ2: dout_o_next = irq2_evt;
			default: dout_oe_next = 1'h0;
		endcase
		// miso pin drives only in a gp output or irq role, whatever the bus mode
		miso_o_next = 1'h0;
		miso_oe_next = 1'h1;
		case (cfg_reg.fn_miso)
			CPM_FN_GPOUT: miso_o_next = cfg_reg.gpo_val[1];
			CPM_FN_IRQ1: miso_o_next = irq1_evt;
			CPM_FN_IRQ2: miso_o_next = irq2_evt;
			default: miso_oe_next = 1'h0;
		endcase
		gpio_o_next = 1'h0;
		gpio_oe_next = 1'h1;
		case (cfg_reg.fn_gpio)
			CPM_FN_GPOUT: gpio_o_next = cfg_reg.gpo_val[2];
			CPM_FN_IRQ1: gpio_o_next = irq1_evt;
			CPM_FN_IRQ2: gpio_o_next = irq2_evt;
			default: gpio_oe_next = 1'h0;
		endcase
		// inputs read only when the pin is given that role
		gpi_next[0] = (cfg_reg.fn_din == CPM_FN_GPIN) & ps.din;
		gpi_next[1] = (cfg_reg.fn_sclk == CPM_FN_GPIN) & ps.sclk;
		gpi_next[2] = (cfg_reg.fn_gpio == CPM_FN_GPIN) & ps.gpio;
		// pll reference; din must be allocated exclusively
		case (cfg_reg.pll_src)
			CPM_PLL_MCLK: pll_ref_next = ps.mclk;
			CPM_PLL_BCLK: pll_ref_next = ps.bclk;
			CPM_PLL_DIN: pll_ref_next = (cfg_reg.fn_din == CPM_FN_CLKIN) & ps.din;
			default: pll_ref_next = (cfg_reg.fn_gpio == CPM_FN_CLKIN) & ps.gpio;
		endcase
		// shared clock pins may fan out at once
		case (cfg_reg.cdc_src)
			CPM_CDC_MCLK: codec_clk_next = ps.mclk;
			CPM_CDC_BCLK: codec_clk_next = ps.bclk;
			CPM_CDC_GPIO: codec_clk_next = (cfg_reg.fn_gpio == CPM_FN_CLKIN) & ps.gpio;
			default: codec_clk_next = pll_ref_next;
		endcase
		bclk_int_next = ps.bclk;
		pwr_next = cfg_reg.pwr_en;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			dout_o <= 1'h0;
			dout_oe <= 1'h0;
			miso_o <= 1'h0;
			miso_oe <= 1'h0;
			gpio_o <= 1'h0;
			gpio_oe <= 1'h0;
			use_spi <= 1'h0;
			i2c_scl <= 1'h1;
			i2c_sda <= 1'h1;
			spi_ss <= 1'h1;
			spi_mosi <= 1'h0;
			pll_ref <= 1'h0;
			codec_clk <= 1'h0;
			bclk_int <= 1'h0;
			gpi_val <= 3'h0;
			pwr_on <= PWR_RESET;
		end else begin
			dout_o <= dout_o_next;
			dout_oe <= dout_oe_next;
			miso_o <= miso_o_next;
			miso_oe <= miso_oe_next;
			gpio_o <= gpio_o_next;
			gpio_oe <= gpio_oe_next;
			use_spi <= use_spi_next;
			i2c_scl <= i2c_scl_next;
			i2c_sda <= i2c_sda_next;
			spi_ss <= spi_ss_next;
			spi_mosi <= spi_mosi_next;
			pll_ref <= pll_ref_next;
			codec_clk <= codec_clk_next;
			bclk_int <= bclk_int_next;
			gpi_val <= gpi_next;
			pwr_on <= pwr_next;
		end
	end
	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_default_roles;
		cfg_reg == CFG_RESET ##1 (dout_oe && !miso_oe && !gpio_oe);
	endsequence
	sequence s_pll_mclk_held;
		cfg_reg.pll_src == CPM_PLL_MCLK ##1 cfg_reg.pll_src == CPM_PLL_MCLK;
	endsequence
	// outputs are one register behind the synchronised pins
	property p_spi_route;
		$past(ps.bus_sel) |-> i2c_scl && spi_ss == $past(ps.bus_a);
	endproperty
	property p_gpo_drive;
		cfg_reg.fn_gpio == CPM_FN_GPOUT |=> gpio_oe && gpio_o == $past(cfg_reg.gpo_val[2]);
	endproperty
	property p_gpio_exclusive;
		cfg_reg.fn_gpio == CPM_FN_GPOUT && irq1_evt != cfg_reg.gpo_val[2]
			|=> gpio_o != $past(irq1_evt);
	endproperty
	property p_bclk_share;
		cfg_reg.pll_src == CPM_PLL_BCLK && cfg_reg.cdc_src == CPM_CDC_BCLK
			|=> pll_ref == bclk_int && codec_clk == bclk_int;
	endproperty
	AST_SPI_SEL: assert property (p_spi_route)
		else $error("spi select not followed");
	AST_FIXED: assert property (use_spi == $past(ps.bus_sel))
		else $error("select mode mismatch");
	AST_RST_DEF: assert property ($rose(rst_b) |-> s_default_roles)
		else $error("pin not in default after reset");
	AST_PWR: assert property (pwr_on == $past(cfg_reg.pwr_en))
		else $error("analog enable not its own setting");
	AST_PLL: assert property (s_pll_mclk_held |-> pll_ref == $past(ps.mclk))
		else $error("pll ref wrong");
	AST_GPO: assert property (p_gpo_drive)
		else $error("gpio output wrong");
	AST_GPI: assert property (cfg_reg.fn_sclk != CPM_FN_GPIN |=> !gpi_val[1])
		else $error("gp input leaked");
	AST_EXCL: assert property (p_gpio_exclusive)
		else $error("gpio not exclusive");
	AST_SHARE: assert property (p_bclk_share)
		else $error("bclk fan out wrong");
endmodule : cpm_pin_mux

/* File: dv/cpm_host_model.sv */
`timescale 1ns/1ns
module cpm_host_model
	import cpm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// request from the bench
	input wire cpm_cfg_type req,
	input wire logic load,
	// configuration to the block
	output cpm_cfg_type cfg
);
	logic pwr_pend;
	// pins first, power one cycle later, so no block wakes on a stale pin role
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg <= CFG_RESET;
			pwr_pend <= 1'h0;
		end else if (load) begin
			cfg <= req;
			cfg.pwr_en <= cfg.pwr_en;
			pwr_pend <= 1'h1;
		end else if (pwr_pend) begin
			cfg.pwr_en <= req.pwr_en;
			pwr_pend <= 1'h0;
		end
	end
endmodule : cpm_host_model

/* File: dv/cpm_pin_mux_tb.sv */
`timescale 1ns/1ns
module cpm_pin_mux_tb;
	import cpm_pkg::*;
	localparam cpm_func_type OUT_SET[4] = '{CPM_FN_DEFAULT, CPM_FN_GPOUT, CPM_FN_IRQ1, CPM_FN_IRQ2};
	localparam cpm_func_type DIN_SET[3] = '{CPM_FN_DEFAULT, CPM_FN_GPIN, CPM_FN_CLKIN};
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic load = 1'h0;
	logic irq1_evt = 1'h0;
	logic irq2_evt = 1'h0;
	logic dout_data = 1'h0;
	cpm_cfg_type req = CFG_RESET;
	cpm_cfg_type cfg;
	cpm_pins_type pins_in = '0;
	logic dout_o, dout_oe, miso_o, miso_oe, gpio_o, gpio_oe, use_spi, i2c_scl, i2c_sda;
	logic spi_ss, spi_mosi, pll_ref, codec_clk, bclk_int;
	logic [2:0] gpi_val;
	logic [PWR_W-1:0] pwr_on;
	int err_count = 0;
	int checks = 0;
	always #5 sys_clk = ~sys_clk;
	cpm_host_model u_cpm_host_model(.sys_clk, .rst_b, .req, .load, .cfg);
	cpm_pin_mux u_cpm_pin_mux(.sys_clk, .rst_b, .cfg, .irq1_evt, .irq2_evt, .dout_data, .pins_in,
		.dout_o, .dout_oe, .miso_o, .miso_oe, .gpio_o, .gpio_oe, .use_spi, .i2c_scl, .i2c_sda,
		.spi_ss, .spi_mosi, .pll_ref, .codec_clk, .bclk_int, .gpi_val, .pwr_on);
	// ----------------------------------------------------------
	// expectations
	// ----------------------------------------------------------
	function automatic logic [1:0] drv(cpm_func_type f, logic d_oe, logic d, logic g);
		case (f)
			CPM_FN_DEFAULT: return {d_oe, d_oe & d};
			CPM_FN_GPOUT: return {1'h1, g};
			CPM_FN_IRQ1: return {1'h1, irq1_evt};
			CPM_FN_IRQ2: return {1'h1, irq2_evt};
			default: return 2'h0;
		endcase
	endfunction : drv
	function automatic logic pll(cpm_cfg_type c, cpm_pins_type p);
		case (c.pll_src)
			CPM_PLL_MCLK: return p.mclk;
			CPM_PLL_BCLK: return p.bclk;
			CPM_PLL_DIN: return p.din & (c.fn_din == CPM_FN_CLKIN);
			default: return p.gpio & (c.fn_gpio == CPM_FN_CLKIN);
		endcase
	endfunction : pll
	function automatic logic cdc_exp(cpm_cfg_type c, cpm_pins_type p);
		case (c.cdc_src)
			CPM_CDC_MCLK: return p.mclk;
			CPM_CDC_BCLK: return p.bclk;
			CPM_CDC_GPIO: return p.gpio & (c.fn_gpio == CPM_FN_CLKIN);
			default: return pll(c, p);
		endcase
	endfunction : cdc_exp
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task check_all;
		cpm_pins_type p;
		p = pins_in;
		chk("bus", {use_spi, i2c_scl, i2c_sda, spi_ss, spi_mosi}, p.bus_sel ?
			{3'h7, p.bus_a, p.bus_b} : {1'h0, p.bus_a, p.bus_b, 2'h2});
		chk("dout", {dout_oe, dout_oe & dout_o},
			drv(cfg.fn_dout, 1'h1, dout_data, cfg.gpo_val[0]));
		chk("miso", {miso_oe, miso_oe & miso_o}, drv(cfg.fn_miso, 1'h0, 1'h0, cfg.gpo_val[1]));
		chk("gpio", {gpio_oe, gpio_oe & gpio_o}, drv(cfg.fn_gpio, 1'h0, 1'h0, cfg.gpo_val[2]));
		chk("gpi", gpi_val, {p.gpio & (cfg.fn_gpio == CPM_FN_GPIN),
			p.sclk & (cfg.fn_sclk == CPM_FN_GPIN), p.din & (cfg.fn_din == CPM_FN_GPIN)});
		chk("pll", pll_ref, pll(cfg, p));
		chk("clk", {codec_clk, bclk_int}, {cdc_exp(cfg, p), p.bclk});
		chk("pwr", pwr_on, cfg.pwr_en);
	endtask : check_all
	task run(input cpm_cfg_type c);
		@(posedge sys_clk);
		req <= c;
		load <= 1'h1;
		pins_in <= cpm_pins_type'($urandom);
		irq1_evt <= 1'($urandom);
		irq2_evt <= 1'($urandom);
		dout_data <= 1'($urandom);
		@(posedge sys_clk);
		load <= 1'h0;
		// settles in three cycles; six leaves margin for the delayed power step
		repeat (6) @(posedge sys_clk);
		#1 check_all;
	endtask : run
	task results;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	// ----------------------------------------------------------
	// sequence
	// ----------------------------------------------------------
	initial begin
		cpm_cfg_type c;
		void'($urandom(61294));
		repeat (15) @(posedge sys_clk);
		#1 chk("rst_oe", {dout_oe, miso_oe, gpio_oe, pwr_on}, 8'h0);
		for (int r = 0; r < 2; r++) begin
			@(posedge sys_clk);
			rst_b <= 1'h1;
			repeat (6) @(posedge sys_clk);
			#1 check_all;
			for (int i = 0; i < 6; i++) begin
				c = CFG_RESET;
				c.fn_gpio = cpm_func_type'(i);
				c.fn_din = CPM_FN_CLKIN;
				c.pll_src = cpm_pll_src_type'(i % 4);
				c.gpo_val = 3'h7;
				c.pwr_en = 4'h1 << (i % 4);
				run(c);
			end
			for (int n = 0; n < 100; n++) begin
				c.fn_din = DIN_SET[$urandom % 3];
				c.fn_dout = OUT_SET[$urandom % 4];
				c.fn_miso = OUT_SET[$urandom % 4];
				c.fn_sclk = cpm_func_type'($urandom % 2);
				c.fn_gpio = cpm_func_type'($urandom % 6);
				c.pll_src = cpm_pll_src_type'($urandom % 4);
				c.cdc_src = cpm_cdc_src_type'($urandom % 4);
				c.gpo_val = 3'($urandom);
				c.pwr_en = PWR_W'($urandom);
				run(c);
			end
			// mid-run reset must drop every enable again
			@(posedge sys_clk);
			rst_b <= 1'h0;
			repeat (3) @(posedge sys_clk);
			#1 chk("rst_pwr", {dout_oe, miso_oe, gpio_oe, pwr_on}, 8'h0);
		end
		results;
	end
	initial begin
		#100000;
		err_count++;
		results;
	end
endmodule : cpm_pin_mux_tb
